// [verilog/fes_regs.svh]
`ifndef FES_REGS_SVH
`define FES_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FES_OFS_STATUS 3'h0
`define FES_OFS_INDEX 3'h1
`define FES_OFS_OBJECT 3'h2
`define FES_OFS_SECURITY 3'h3
`define FES_OFS_PROTECT 3'h4
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define FES_BIT_DONE 7
`define FES_BIT_ACC 5
`define FES_BIT_PVIOL 4
`define FES_BIT_VERR 1
`define FES_BIT_VFATAL 0
// ----------------------------------------
// protect register fields
// ----------------------------------------
`define FES_BIT_PROT_D 15
`define FES_BIT_PROT_P 14
`define FES_PROT_BOUND_MSB 6
// ----------------------------------------
// command codes, indices, map
// ----------------------------------------
`define FES_CMD_ERASE_BLOCK 8'h09
`define FES_CMD_ERASE_SECTOR 8'h0a
`define FES_CMD_UNSECURE 8'h0b
`define FES_CMD_KEY_VERIFY 8'h0c
`define FES_IDX_ADDR_ONLY 3'h0
`define FES_IDX_ADDR 3'h1
`define FES_IDX_KEY 3'h4
`define FES_NUM_WORDS 5
`define FES_UPPER_DFLASH 2'h0
`define FES_UPPER_PFLASH 2'h3
`define FES_KEY_EN_ON 2'h2
`define FES_SEC_OPEN 2'h2
`define FES_PROT_BOUND_RST 7'h7f
`endif

// [verilog/fes_pkg.sv]
`default_nettype none
package fes_pkg;
  typedef enum logic [4:0] {
    FES_IDLE = 5'h01,
    FES_CHECK = 5'h02,
    FES_ERASE = 5'h04,
    FES_VERIFY = 5'h08,
    FES_KEYCMP = 5'h10
  } fes_state_type;

  typedef enum logic [1:0] {
    FES_SCOPE_BLOCK = 2'h0,
    FES_SCOPE_SECTOR = 2'h1,
    FES_SCOPE_ALL = 2'h2
  } fes_scope_type;

  // request to the flash array macro
  typedef struct packed {
    logic erase;
    logic verify;
    fes_scope_type scope;
    logic [17:0] addr;
  } fes_fm_req_type;

  // answer of the flash array macro
  typedef struct packed {
    logic done;
    logic err;
    logic fatal;
  } fes_fm_rsp_type;

  typedef struct packed {
    fes_state_type st;
    logic loaded;
    logic cmd_done;
    logic acc;
    logic pviol;
    logic verr;
    logic vfatal;
    logic key_lock;
    logic [2:0] idx;
    logic [4:0][15:0] word;
    logic [1:0] sec;
    logic [1:0] key_en;
    logic prot_d;
    logic prot_p;
    logic [6:0] prot_bound;
    logic [15:0] rdata;
    fes_fm_req_type fm;
  } fes_regs_type;
endpackage : fes_pkg
`default_nettype wire

// [verilog/fes_flash_cmd.sv]
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "fes_regs.svh"
`default_nettype none
module fes_flash_cmd
  import fes_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // configuration field and mode
  input wire logic [1:0] cfg_sec_i,
  input wire logic [1:0] cfg_key_en_i,
  input wire logic [3:0][15:0] cfg_key_i,
  input wire logic [3:0] cmd_permit_i,
  // flash array macro
  output fes_fm_req_type fm_req_o,
  input wire fes_fm_rsp_type fm_rsp_i,
  // status
  output logic cmd_complete_flag_o,
  output logic secure_o
);

  fes_regs_type r_ff;
  fes_regs_type nxt_r;

  logic [7:0] cmd;
  logic [17:0] gaddr;
  logic up_p;
  logic up_d;
  logic key_match;
  logic [3:0] key_eq;

  assign cmd = r_ff.word[0][15:8];
  assign gaddr = {r_ff.word[0][1:0], r_ff.word[1]};
  assign up_p = (gaddr[17:16] == `FES_UPPER_PFLASH);
  assign up_d = (gaddr[17:16] == `FES_UPPER_DFLASH);

  // ----------------------------------------
  // key word compare
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_key
      assign key_eq[gi] = (r_ff.word[gi + 1] == cfg_key_i[gi]);
    end
  endgenerate
  assign key_match = &key_eq;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.rdata = 16'h0000;
    // configuration captured once after reset release
    if (!r_ff.loaded) begin
      nxt_r.loaded = 1'b1;
      nxt_r.sec = cfg_sec_i;
      nxt_r.key_en = cfg_key_en_i;
      nxt_r.cmd_done = 1'b1;
    end
    // register reads
    if (reg_rd_i) begin
      case (reg_addr_i)
        `FES_OFS_STATUS: begin
          nxt_r.rdata[`FES_BIT_DONE] = r_ff.cmd_done;
          nxt_r.rdata[`FES_BIT_ACC] = r_ff.acc;
          nxt_r.rdata[`FES_BIT_PVIOL] = r_ff.pviol;
          nxt_r.rdata[`FES_BIT_VERR] = r_ff.verr;
          nxt_r.rdata[`FES_BIT_VFATAL] = r_ff.vfatal;
        end
        `FES_OFS_INDEX: nxt_r.rdata = {13'h0000, r_ff.idx};
        `FES_OFS_OBJECT: begin
          if (r_ff.idx < 3'(`FES_NUM_WORDS)) begin
            nxt_r.rdata = r_ff.word[r_ff.idx];
          end
        end
        `FES_OFS_SECURITY: nxt_r.rdata = {8'h00, r_ff.key_en, 4'h0, r_ff.sec};
        `FES_OFS_PROTECT: begin
          nxt_r.rdata[`FES_BIT_PROT_D] = r_ff.prot_d;
          nxt_r.rdata[`FES_BIT_PROT_P] = r_ff.prot_p;
          nxt_r.rdata[`FES_PROT_BOUND_MSB:0] = r_ff.prot_bound;
        end
        default: nxt_r.rdata = 16'h0000;
      endcase
    end
    // register writes, ignored while a command runs
    if (reg_wr_i && r_ff.cmd_done && r_ff.loaded) begin
      case (reg_addr_i)
        `FES_OFS_STATUS: begin
          if (reg_wdata_i[`FES_BIT_ACC]) begin
            nxt_r.acc = 1'b0;
          end
          if (reg_wdata_i[`FES_BIT_PVIOL]) begin
            nxt_r.pviol = 1'b0;
          end
          // launch by clearing the complete flag, only with no pending access or protection error
          if (reg_wdata_i[`FES_BIT_DONE] && !r_ff.acc && !r_ff.pviol) begin
            nxt_r.cmd_done = 1'b0;
            nxt_r.verr = 1'b0;
            nxt_r.vfatal = 1'b0;
            nxt_r.st = FES_CHECK;
          end
        end
        `FES_OFS_INDEX: nxt_r.idx = reg_wdata_i[2:0];
        `FES_OFS_OBJECT: begin
          if (r_ff.idx < 3'(`FES_NUM_WORDS)) begin
            nxt_r.word[r_ff.idx] = reg_wdata_i;
          end
        end
        `FES_OFS_PROTECT: begin
          nxt_r.prot_d = reg_wdata_i[`FES_BIT_PROT_D];
          nxt_r.prot_p = reg_wdata_i[`FES_BIT_PROT_P];
          nxt_r.prot_bound = reg_wdata_i[`FES_PROT_BOUND_MSB:0];
        end
        default: nxt_r.idx = r_ff.idx;
      endcase
    end
    // command sequencer
    case (r_ff.st)
      FES_IDLE: nxt_r.fm = r_ff.fm;
      FES_CHECK: begin
        nxt_r.st = FES_IDLE;
        nxt_r.cmd_done = 1'b1;
        nxt_r.fm.addr = gaddr;
        case (cmd)
          `FES_CMD_ERASE_BLOCK: begin
            nxt_r.fm.scope = FES_SCOPE_BLOCK;
            if (r_ff.idx != `FES_IDX_ADDR || !cmd_permit_i[0] || (!up_p && !up_d) ||
                (up_p && gaddr[2:0] != 3'h0) || (up_d && gaddr[0])) begin
              nxt_r.acc = 1'b1;
            end else if ((up_p && r_ff.prot_p) || (up_d && r_ff.prot_d)) begin
              nxt_r.pviol = 1'b1;
            end else begin
              nxt_r.cmd_done = 1'b0;
              nxt_r.st = FES_ERASE;
            end
          end
          `FES_CMD_ERASE_SECTOR: begin
            nxt_r.fm.scope = FES_SCOPE_SECTOR;
            if (r_ff.idx != `FES_IDX_ADDR || !cmd_permit_i[1] || !up_p ||
                gaddr[2:0] != 3'h0) begin
              nxt_r.acc = 1'b1;
            end else if (r_ff.prot_p && gaddr[15:9] >= r_ff.prot_bound) begin
              nxt_r.pviol = 1'b1;
            end else begin
              nxt_r.cmd_done = 1'b0;
              nxt_r.st = FES_ERASE;
            end
          end
          `FES_CMD_UNSECURE: begin
            nxt_r.fm.scope = FES_SCOPE_ALL;
            if (r_ff.idx != `FES_IDX_ADDR_ONLY || !cmd_permit_i[2]) begin
              nxt_r.acc = 1'b1;
            end else if (r_ff.prot_p || r_ff.prot_d) begin
              nxt_r.pviol = 1'b1;
            end else begin
              nxt_r.cmd_done = 1'b0;
              nxt_r.st = FES_ERASE;
            end
          end
          `FES_CMD_KEY_VERIFY: begin
            if (r_ff.idx != `FES_IDX_KEY || !cmd_permit_i[3] ||
                r_ff.key_en != `FES_KEY_EN_ON || r_ff.key_lock) begin
              nxt_r.acc = 1'b1;
            end else begin
              nxt_r.cmd_done = 1'b0;
              nxt_r.st = FES_KEYCMP;
            end
          end
          default: nxt_r.acc = 1'b1;
        endcase
      end
      FES_ERASE: begin
        nxt_r.fm.erase = 1'b1;
        if (r_ff.fm.erase && fm_rsp_i.done) begin
          nxt_r.fm.erase = 1'b0;
          nxt_r.fm.verify = 1'b1;
          nxt_r.st = FES_VERIFY;
        end
      end
      FES_VERIFY: begin
        if (fm_rsp_i.done) begin
          nxt_r.fm.verify = 1'b0;
          nxt_r.verr = fm_rsp_i.err;
          nxt_r.vfatal = fm_rsp_i.fatal;
          if (r_ff.fm.scope == FES_SCOPE_ALL && !fm_rsp_i.err) begin
            nxt_r.sec = `FES_SEC_OPEN;
          end
          nxt_r.cmd_done = 1'b1;
          nxt_r.st = FES_IDLE;
        end
      end
      FES_KEYCMP: begin
        if (key_match) begin
          nxt_r.sec = `FES_SEC_OPEN;
        end else begin
          nxt_r.acc = 1'b1;
          nxt_r.key_lock = 1'b1;
        end
        nxt_r.cmd_done = 1'b1;
        nxt_r.st = FES_IDLE;
      end
      default: nxt_r.st = FES_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      r_ff <= '0;
      r_ff.st <= FES_IDLE;
      r_ff.prot_bound <= `FES_PROT_BOUND_RST;
    end else if (ce_i) begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata_o = r_ff.rdata;
  assign fm_req_o = r_ff.fm;
  assign cmd_complete_flag_o = r_ff.cmd_done;
  assign secure_o = (r_ff.sec != `FES_SEC_OPEN);

endmodule : fes_flash_cmd
`default_nettype wire

// [testbench/fes_flash_cmd_asserts.sv]
`default_nettype none
module fes_flash_cmd_chk
  import fes_pkg::*;
(
  // clock, reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic ce_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // flash macro, status
  input wire fes_fm_req_type fm_req_o,
  input wire fes_fm_rsp_type fm_rsp_i,
  input wire logic cmd_complete_flag_o,
  input wire logic secure_o
);
  // ----
  // sequencing
  // ----
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  AST_IDLE_NO_FM: assert property (
    cmd_complete_flag_o |-> !(fm_req_o.erase || fm_req_o.verify)) else $error("fm while idle");
  AST_ONE_PHASE: assert property (
    !(fm_req_o.erase && fm_req_o.verify)) else $error("erase with verify");
  AST_ERASE_HOLD: assert property (
    fm_req_o.erase && !fm_rsp_i.done |=> fm_req_o.erase) else $error("erase dropped");
  AST_VERIFY_NEXT: assert property (
    fm_req_o.erase && fm_rsp_i.done |=> !fm_req_o.erase && fm_req_o.verify)
    else $error("no verify");
  AST_DONE_NEXT: assert property (
    fm_req_o.verify && fm_rsp_i.done |=> !fm_req_o.verify && cmd_complete_flag_o)
    else $error("no complete");
  AST_FALL_CAUSE: assert property (
    $fell(cmd_complete_flag_o) |->
    $past(ce_i && reg_wr_i && reg_addr_i == 3'h0 && reg_wdata_i[7])) else $error("bad fall");
  AST_START_BOUND: assert property (
    $fell(cmd_complete_flag_o) |-> ##[1:2] (cmd_complete_flag_o || fm_req_o.erase))
    else $error("no start");
  AST_SEC_AT_END: assert property (
    $changed(secure_o) |-> $rose(cmd_complete_flag_o)) else $error("secure moved");
  cover property ($rose(fm_req_o.verify));
  cover property ($fell(secure_o));
  cover property ($rose(cmd_complete_flag_o));
endmodule // fes_flash_cmd_chk
bind fes_flash_cmd fes_flash_cmd_chk fes_flash_cmd_chk_i (.core_clk_i, .srst_i, .ce_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .fm_req_o, .fm_rsp_i, .cmd_complete_flag_o, .secure_o);
`default_nettype wire

// [testbench/tb_fes_flash_cmd.sv]
`default_nettype none
module tb_fes_flash_cmd;
  timeunit 1ns;
  timeprecision 1ps;
  import fes_pkg::*;
  localparam logic [3:0][15:0] KEY = 64'h4d4c_3b3a_2928_1716;
  logic core_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0, cnt = 3'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
  logic [1:0] cfg_sec_i = 2'h0, cfg_key_en_i = 2'h2;
  logic [3:0] cmd_permit_i = 4'hf;
  fes_fm_rsp_type fm_rsp_i = '0;
  fes_fm_req_type fm_req_o;
  logic cmd_complete_flag_o, secure_o, e_cfg = 1'b0, f_cfg = 1'b0;
  int bad_count = 0, tests_run = 0;
  fes_flash_cmd fes_flash_cmd_i (.core_clk_i, .srst_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cfg_sec_i, .cfg_key_en_i, .cfg_key_i(KEY),
    .cmd_permit_i, .fm_req_o, .fm_rsp_i, .cmd_complete_flag_o, .secure_o);
  // ----
  // flash macro stand-in, bus tasks
  // ----
  initial forever #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    fm_rsp_i <= '0;
    cnt <= (fm_req_o.erase || fm_req_o.verify) ? cnt + 3'h1 : 3'h0;
    if (cnt == 3'h3) begin
      fm_rsp_i <= {1'b1, e_cfg && fm_req_o.verify, f_cfg && fm_req_o.verify};
      cnt <= 3'h0;
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    #1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] ex);
    #1;
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg", ex, reg_rdata_o);
  endtask
  task automatic wt();
    int n;
    n = 0;
    repeat (2) @(posedge core_clk_i);
    while (cmd_complete_flag_o !== 1'b1 && n < 100) begin
      #1 @(posedge core_clk_i);
      n++;
    end
    if (n >= 100) begin
      chk("complete", 16'h0001, 16'h0000);
      test_done();
    end
  endtask
  task automatic rst(input logic [1:0] ken);
    #1;
    cfg_key_en_i <= ken;
    srst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic s(input logic x);
    #1 chk("secure", 16'(x), 16'(secure_o));
  endtask
  task automatic c(input logic [7:0] op, input logic [1:0] up, input logic [3:0][15:0] k,
    input logic [2:0] ix, input logic [7:0] ex);
    wr(3'h0, 16'h0030);
    wr(3'h1, 16'h0000);
    wr(3'h2, {op, 6'h00, up});
    for (int i = 0; i < 4; i++) begin
      wr(3'h1, 16'(i + 1));
      wr(3'h2, k[i]);
    end
    wr(3'h1, {13'h0000, ix});
    wr(3'h0, 16'h0080);
    wt();
    rd(3'h0, {8'h00, ex});
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_erase();
    c(8'h09, 2'h3, 64'h0, 3'h1, 8'h80);
    c(8'h09, 2'h3, 64'h0, 3'h0, 8'ha0);
    c(8'h09, 2'h0, 64'h1, 3'h1, 8'ha0);
    c(8'h09, 2'h3, 64'h4, 3'h1, 8'ha0);
    c(8'h09, 2'h1, 64'h0, 3'h1, 8'ha0);
    wr(3'h4, 16'h407f);
    c(8'h09, 2'h3, 64'h0, 3'h1, 8'h90);
    c(8'h0a, 2'h3, 64'hfe00, 3'h1, 8'h90);
    c(8'h0a, 2'h3, 64'hfc00, 3'h1, 8'h80);
    wr(3'h4, 16'h007f);
    e_cfg = 1'b1;
    c(8'h09, 2'h0, 64'h2, 3'h1, 8'h82);
    f_cfg = 1'b1;
    c(8'h0b, 2'h0, 64'h0, 3'h0, 8'h83);
    s(1'b1);
    e_cfg = 1'b0;
    f_cfg = 1'b0;
    $display("test t_erase done");
  endtask
  task automatic t_sector();
    c(8'h0a, 2'h3, 64'h8, 3'h1, 8'h80);
    c(8'h0a, 2'h3, 64'h4, 3'h1, 8'ha0);
    c(8'h0a, 2'h3, 64'h8, 3'h0, 8'ha0);
    wr(3'h0, 16'h0030);
    wr(3'h1, 16'h0001);
    wr(3'h0, 16'h0080);
    @(posedge core_clk_i);
    #1 chk("complete", 16'h0000, 16'(cmd_complete_flag_o));
    chk("fm_addr", 16'h0008, fm_req_o.addr[15:0]);
    chk("fm_scope", 16'(FES_SCOPE_SECTOR), 16'(fm_req_o.scope));
    wr(3'h1, 16'h0000);
    wt();
    rd(3'h1, 16'h0001);
    $display("test t_sector done");
  endtask
  task automatic t_unsecure();
    c(8'h0b, 2'h0, 64'h0, 3'h1, 8'ha0);
    wr(3'h4, 16'h807f);
    c(8'h0b, 2'h0, 64'h0, 3'h0, 8'h90);
    wr(3'h4, 16'h007f);
    c(8'h0b, 2'h0, 64'h0, 3'h0, 8'h80);
    s(1'b0);
    $display("test t_unsecure done");
  endtask
  task automatic t_key();
    rst(2'h2);
    cmd_permit_i <= 4'h0;
    c(8'h09, 2'h3, 64'h0, 3'h1, 8'ha0);
    c(8'h0a, 2'h3, 64'h8, 3'h1, 8'ha0);
    c(8'h0b, 2'h0, 64'h0, 3'h0, 8'ha0);
    c(8'h0c, 2'h0, KEY, 3'h4, 8'ha0);
    cmd_permit_i <= 4'hf;
    c(8'h0c, 2'h0, KEY, 3'h3, 8'ha0);
    c(8'h0c, 2'h0, KEY, 3'h4, 8'h80);
    s(1'b0);
    rst(2'h2);
    c(8'h0c, 2'h0, KEY ^ 64'h0001_0000_0000_0000, 3'h4, 8'ha0);
    c(8'h0c, 2'h0, KEY, 3'h4, 8'ha0);
    s(1'b1);
    rst(2'h0);
    c(8'h0c, 2'h0, KEY, 3'h4, 8'ha0);
    s(1'b1);
    $display("test t_key done");
  endtask
  initial begin
    rst(2'h2);
    s(1'b1);
    t_erase();
    t_sector();
    t_unsecure();
    t_key();
    test_done();
  end
endmodule // tb_fes_flash_cmd
`default_nettype wire
